// ==== design/irqep_regs.sv ====
// APB register block holding the enable and pending state of 103 interrupt lines.
// Assumes an APB master on sys_clk_i, level interrupt sources and an active mask from the core.
`timescale 1ns/1ps

// Summary of operation
// - Writing one to a line's bit in the disable view turns that line's enable off.
// - Zero bits written to the disable or pend view leave enable and pending state unchanged.
// - Reading the disable view returns each line's enable state, one meaning enabled.
// - Writing one to a line's bit in the pend view makes that line pending.
// - A pend-view write has no effect on a line already pending or currently disabled.
// - Reading the pend view returns each line's pending state, one meaning pending.
// - Lines 0 to 102 sit thirty-two per word in ascending order, the fourth word using bits 6 to 0 only.
// - Pending is cleared only through the pending-clear view, never by writing the pend view.
// - Writing one to a line's bit in the enable-set view turns that line's enable on.
// - Writing one in the pending-clear view clears pending except for a line whose handling has started or whose enabled source is requesting.
module irqep_regs
  import irqep_pkg::*;
(
  input  wire logic                  sys_clk_i,     // System clock, 100 MHz
  input  wire logic                  reset_i,       // Synchronous reset, active high
  input  wire irqep_apb_req_t        apb_req_i,     // APB request signals
  output irqep_apb_rsp_t             apb_rsp_o,     // APB response, registered
  input  wire logic [IRQ_COUNT-1:0]  irq_src_i,     // Peripheral interrupt requests
  input  wire logic [IRQ_COUNT-1:0]  irq_active_i,  // Lines whose handling has started
  output logic      [IRQ_COUNT-1:0]  irq_enable_o,  // Enable state, from flops
  output logic      [IRQ_COUNT-1:0]  irq_pending_o  // Pending state, from flops
);

  // ****************************************
  // Address decode
  // ****************************************
  irqep_apb_rsp_t          rsp_reg;
  irqep_apb_rsp_t          rsp_next;
  irqep_view_t             view;
  logic [1:0]              word_idx;
  logic                    mapped;
  logic                    setup_phase;
  logic                    access_done;
  logic                    wr_go;
  logic                    wr_set;
  logic                    wr_dis;
  logic                    wr_pend;
  logic                    wr_pclr;
  logic [PAD_W-1:0]        wr_wide;
  logic [IRQ_COUNT-1:0]    wr_bits;
  logic [PAD_W-1:0]        en_pad;
  logic [PAD_W-1:0]        pend_pad;
  logic [31:0]             en_word;
  logic [31:0]             pend_word;

  assign view        = irqep_view_t'(apb_req_i.paddr[VIEW_LSB +: 2]);
  assign word_idx    = apb_req_i.paddr[WORD_LSB +: 2];
  assign mapped      = (apb_req_i.paddr[ADDR_W-1:MAP_LSB] == '0);
  assign setup_phase = apb_req_i.psel && !apb_req_i.penable;
  // A write lands only on the edge that completes the access phase
  assign access_done = apb_req_i.psel && apb_req_i.penable && rsp_reg.pready;
  assign wr_go       = access_done && apb_req_i.pwrite && mapped;
  assign wr_set      = wr_go && (view == VIEW_ENA_SET);
  assign wr_dis      = wr_go && (view == VIEW_DISABLE);
  assign wr_pend     = wr_go && (view == VIEW_PEND);
  assign wr_pclr     = wr_go && (view == VIEW_PEND_CLR);

  // Write data placed at the line numbers of the addressed word
  assign wr_wide  = PAD_W'(apb_req_i.pwdata) << {word_idx, 5'h00};
  assign wr_bits  = wr_wide[IRQ_COUNT-1:0];

  // ****************************************
  // State words
  // ****************************************
  genvar w;
  generate
    for (w = 0; w < WORD_COUNT; w = w + 1) begin : g_word
      localparam int LO = w * WORD_W;
      localparam int WW = (w == WORD_COUNT - 1) ? LAST_W : WORD_W;
      logic wsel;
      assign wsel = (word_idx == 2'(w));
      irqep_word #(
        .WIDTH (WW)
      ) u_word (
        .sys_clk_i     (sys_clk_i),
        .reset_i       (reset_i),
        .set_en_we_i   (wr_set && wsel),
        .disable_we_i  (wr_dis && wsel),
        .pend_we_i     (wr_pend && wsel),
        .pend_clr_we_i (wr_pclr && wsel),
        .wdata_i       (apb_req_i.pwdata[WW-1:0]),
        .src_i         (irq_src_i[LO +: WW]),
        .active_i      (irq_active_i[LO +: WW]),
        .enable_o      (irq_enable_o[LO +: WW]),
        .pending_o     (irq_pending_o[LO +: WW])
      );
    end
  endgenerate

  // ****************************************
  // Read path
  // ****************************************
  // Unused lines of the last word pad with zero
  assign en_pad    = {{(PAD_W-IRQ_COUNT){1'b0}}, irq_enable_o};
  assign pend_pad  = {{(PAD_W-IRQ_COUNT){1'b0}}, irq_pending_o};
  assign en_word   = en_pad[{word_idx, 5'h00} +: 32];
  assign pend_word = pend_pad[{word_idx, 5'h00} +: 32];

  // Read data is captured in the setup cycle, so a zero-wait access sees state as of that edge
  always_comb begin
    rsp_next         = rsp_reg;
    rsp_next.pready  = setup_phase;
    if (setup_phase) begin
      rsp_next.pslverr = !mapped;
      rsp_next.prdata  = RDATA_RESET;
      if (mapped && !apb_req_i.pwrite) begin
        unique case (view)
          VIEW_ENA_SET:  rsp_next.prdata = en_word;
          VIEW_DISABLE:  rsp_next.prdata = en_word;
          VIEW_PEND:     rsp_next.prdata = pend_word;
          VIEW_PEND_CLR: rsp_next.prdata = pend_word;
        endcase
      end
    end else if (!apb_req_i.psel) begin
      rsp_next.pslverr = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rsp_reg <= '{prdata: RDATA_RESET, pready: 1'b0, pslverr: 1'b0};
    end else begin
      rsp_reg <= rsp_next;
    end
  end

  assign apb_rsp_o = rsp_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence apb_setup_s;
    apb_req_i.psel && !apb_req_i.penable;
  endsequence

  sequence rd_setup_s;
    apb_setup_s ##0 (!apb_req_i.pwrite && mapped);
  endsequence

  logic [IRQ_COUNT-1:0] src_en_set;
  assign src_en_set = irq_src_i & irq_enable_o;

  apb_ready_next_a: assert property (
    apb_setup_s |=> apb_rsp_o.pready ##1 !apb_rsp_o.pready
  ) else $error("pready not a single cycle after setup");

  apb_unmapped_err_a: assert property (
    apb_setup_s ##0 !mapped |=> apb_rsp_o.pslverr && apb_rsp_o.pready && apb_rsp_o.prdata == 32'h0000_0000
  ) else $error("unmapped access not answered with error");

  disable_clears_a: assert property (
    wr_dis |=> (irq_enable_o & $past(wr_bits)) == '0
  ) else $error("disable write left line enabled");

  zero_keeps_state_a: assert property (
    (wr_dis || wr_pend) |=>
      ((irq_enable_o ^ $past(irq_enable_o)) & ~$past(wr_bits)) == '0 &&
      ($past(irq_pending_o) & ~$past(wr_bits) & ~irq_pending_o) == '0
  ) else $error("zero bit changed enable or pending state");

  pend_view_enable_a: assert property (
    wr_pend |=> irq_enable_o == $past(irq_enable_o)
  ) else $error("pend write changed enable state");

  disable_read_a: assert property (
    rd_setup_s ##0 (view == VIEW_DISABLE) |=> apb_rsp_o.prdata == $past(en_word)
  ) else $error("disable view read does not show enable state");

  pend_sets_a: assert property (
    wr_pend |=> (irq_pending_o & $past(wr_bits & irq_enable_o)) == $past(wr_bits & irq_enable_o)
  ) else $error("pend write did not set pending");

  disabled_no_pend_a: assert property (
    1'b1 |=> (irq_pending_o & ~$past(irq_pending_o) & ~$past(irq_enable_o)) == '0
  ) else $error("disabled line became pending");

  pend_read_a: assert property (
    rd_setup_s ##0 (view == VIEW_PEND) |=> apb_rsp_o.prdata == $past(pend_word)
  ) else $error("pend view read does not show pending state");

  last_word_pad_a: assert property (
    apb_setup_s ##0 (word_idx == 2'h3) |=> apb_rsp_o.prdata[31:LAST_W] == '0
  ) else $error("unused bits of last word read nonzero");

  pend_clear_only_a: assert property (
    (($past(irq_pending_o) & ~irq_pending_o) != '0) |-> $past(wr_pclr)
  ) else $error("pending cleared without pending-clear write");

  enable_set_a: assert property (
    wr_set |=> (irq_enable_o & $past(wr_bits)) == $past(wr_bits) &&
               ((irq_enable_o ^ $past(irq_enable_o)) & ~$past(wr_bits)) == '0
  ) else $error("enable-set write wrong");

  pend_clear_a: assert property (
    wr_pclr |=> (irq_pending_o & $past(wr_bits & ~irq_active_i & ~src_en_set)) == '0
  ) else $error("pending-clear write did not clear");

  active_keeps_a: assert property (
    wr_pclr |=> ($past(irq_pending_o & irq_active_i) & ~irq_pending_o) == '0
  ) else $error("active line lost pending state");

  shared_views_a: assert property (
    rd_setup_s ##0 (view == VIEW_ENA_SET || view == VIEW_PEND_CLR) |=>
      apb_rsp_o.prdata == ($past(view) == VIEW_ENA_SET ? $past(en_word) : $past(pend_word))
  ) else $error("paired views read different state");

endmodule // irqep_regs

// ==== design/irqep_word.sv ====
// One word of interrupt state: an enable flop and a pending flop per line.
// Assumes write strobes are single-cycle and at most one view is written per cycle.
`timescale 1ns/1ps

module irqep_word
  import irqep_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input  wire logic             sys_clk_i,     // System clock
  input  wire logic             reset_i,       // Synchronous reset, active high
  input  wire logic             set_en_we_i,   // Enable-set view written
  input  wire logic             disable_we_i,  // Disable view written
  input  wire logic             pend_we_i,     // Pend view written
  input  wire logic             pend_clr_we_i, // Pending-clear view written
  input  wire logic [WIDTH-1:0] wdata_i,       // Write data bits of this word
  input  wire logic [WIDTH-1:0] src_i,         // Hardware interrupt requests
  input  wire logic [WIDTH-1:0] active_i,      // Handling already started
  output logic      [WIDTH-1:0] enable_o,      // Enable flops
  output logic      [WIDTH-1:0] pending_o      // Pending flops
);

  logic [WIDTH-1:0] enable_next;
  logic [WIDTH-1:0] pend_set;
  logic [WIDTH-1:0] pend_clr;
  logic [WIDTH-1:0] pending_next;

  // ****************************************
  // Enable state
  // ****************************************
  always_comb begin
    enable_next = enable_o;
    if (set_en_we_i) begin
      enable_next = enable_o | wdata_i;
    end
    if (disable_we_i) begin
      enable_next = enable_o & ~wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      enable_o <= ENABLE_RESET[WIDTH-1:0];
    end else begin
      enable_o <= enable_next;
    end
  end

  // ****************************************
  // Pending state
  // ****************************************
  // A disabled line cannot become pending; a set in the same cycle as a clear wins
  always_comb begin
    pend_set     = ((pend_we_i ? wdata_i : '0) | src_i) & enable_o;
    pend_clr     = (pend_clr_we_i ? wdata_i : '0) & ~active_i;
    pending_next = pend_set | (pending_o & ~pend_clr);
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pending_o <= PENDING_RESET[WIDTH-1:0];
    end else begin
      pending_o <= pending_next;
    end
  end

endmodule // irqep_word

// ==== include/irqep_pkg.sv ====
// Constants and carrier types shared by the interrupt enable and pending register block.
// Assumes a 32-bit APB master and 103 interrupt lines, all on one system clock.
package irqep_pkg;

  // ****************************************
  // Interrupt line layout
  // ****************************************
  localparam int IRQ_COUNT  = 103;
  localparam int WORD_W     = 32;
  localparam int WORD_COUNT = 4;
  localparam int LAST_W     = 7;
  localparam int PAD_W      = WORD_W * WORD_COUNT;

  // ****************************************
  // Register map
  // ****************************************
  localparam int           ADDR_W           = 12;
  localparam logic [11:0]  REG_ENA_SET_BASE = 12'h000;
  localparam logic [11:0]  REG_DISABLE_BASE = 12'h010;
  localparam logic [11:0]  REG_PEND_BASE    = 12'h020;
  localparam logic [11:0]  REG_PEND_CLR_BASE = 12'h030;
  localparam logic [11:0]  REG_WORD_STRIDE  = 12'h004;
  localparam int           WORD_LSB         = 2;
  localparam int           VIEW_LSB         = 4;
  localparam int           MAP_LSB          = 6;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0]  ENABLE_RESET     = 32'h0000_0000;
  localparam logic [31:0]  PENDING_RESET    = 32'h0000_0000;
  localparam logic [31:0]  RDATA_RESET      = 32'h0000_0000;

  // Order matches the view field of the address
  typedef enum logic [1:0] {
    VIEW_ENA_SET,
    VIEW_DISABLE,
    VIEW_PEND,
    VIEW_PEND_CLR
  } irqep_view_t;

  typedef struct packed {
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [ADDR_W-1:0]   paddr;
    logic [31:0]         pwdata;
  } irqep_apb_req_t;

  typedef struct packed {
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
  } irqep_apb_rsp_t;

endpackage

// ==== tb/irqep_core_model.sv ====
// Far-side model: peripheral request lines and the core's handling-started mask.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps

module irqep_core_model
  import irqep_pkg::*;
(
  input  wire logic                 sys_clk_i,    // System clock
  output logic      [IRQ_COUNT-1:0] irq_src_o,    // Request per line
  output logic      [IRQ_COUNT-1:0] irq_active_o  // Handling started per line
);
  initial begin
    irq_src_o    = '0;
    irq_active_o = '0;
  end

  // A hold above one models a slow source that keeps its request up
  task automatic pulse(input int line, input int hold);
    @(posedge sys_clk_i);
    irq_src_o[line] <= 1'b1;
    repeat (hold) @(posedge sys_clk_i);
    irq_src_o[line] <= 1'b0;
  endtask

  task automatic mark_active(input int line, input logic level);
    @(posedge sys_clk_i);
    irq_active_o[line] <= level;
  endtask
endmodule // irqep_core_model

// ==== tb/irqep_regs_test.sv ====
// Self-checking bench for the interrupt enable and pending register block.
// Assumes zero-wait APB answers are awaited, never counted on.
`timescale 1ns/1ps

module irqep_regs_test;
  import irqep_pkg::*;
  logic                 sys_clk;
  logic                 reset;
  irqep_apb_req_t       req;
  irqep_apb_rsp_t       rsp;
  logic [IRQ_COUNT-1:0] src;
  logic [IRQ_COUNT-1:0] act;
  logic [IRQ_COUNT-1:0] ena;
  logic [IRQ_COUNT-1:0] pend;
  logic [31:0]          rd;
  logic                 err;
  int                   fails;
  int                   n_checks;

  irqep_regs u_irqep_regs (.sys_clk_i(sys_clk), .reset_i(reset), .apb_req_i(req), .apb_rsp_o(rsp),
    .irq_src_i(src), .irq_active_i(act), .irq_enable_o(ena), .irq_pending_o(pend));
  irqep_core_model u_irqep_core_model (.sys_clk_i(sys_clk), .irq_src_o(src), .irq_active_o(act));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Idle edge first, so a release never meets the next setup in one time step
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    @(posedge sys_clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= addr;
    req.pwdata  <= wdata;
    @(posedge sys_clk);
    req.penable <= 1'b1;
    // Only the watchdog ends a wait for pready
    do begin
      @(posedge sys_clk);
    end while (rsp.pready !== 1'b1);
    rd  = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [11:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0000_0000);
    check(what, rd, exp);
  endtask

  task automatic summarize;
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge sys_clk);
    fails++;
    summarize();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    fails    = 0;
    n_checks = 0;
    req      = '0;
    reset    = 1'b1;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    for (int w = 0; w < 4; w++) begin
      rd_chk("disable view at reset", REG_DISABLE_BASE + 12'(4 * w), 32'h0000_0000);
      rd_chk("pend view at reset", REG_PEND_BASE + 12'(4 * w), 32'h0000_0000);
    end
    apb(1'b1, REG_ENA_SET_BASE, 32'h8000_0001);
    rd_chk("disable view after set", REG_DISABLE_BASE, 32'h8000_0001);
    rd_chk("enable-set view", REG_ENA_SET_BASE, 32'h8000_0001);
    apb(1'b1, REG_DISABLE_BASE, 32'h0000_0001);
    rd_chk("disable view after clear", REG_DISABLE_BASE, 32'h8000_0000);
    @(negedge sys_clk);
    check("enable lines 31..0", ena[31:0], 32'h8000_0000);
    for (int w = 1; w < 4; w++) begin
      apb(1'b1, REG_ENA_SET_BASE + 12'(4 * w), 32'hffff_ffff);
      rd_chk("word packing", REG_DISABLE_BASE + 12'(4 * w), (w == 3) ? 32'h0000_007f : 32'hffff_ffff);
    end
    apb(1'b1, REG_DISABLE_BASE + 12'h004, 32'hffff_ffff);
    rd_chk("word 1 disabled", REG_DISABLE_BASE + 12'h004, 32'h0000_0000);
    @(negedge sys_clk);
    check("enable lines 102..96", {25'h0, ena[102:96]}, 32'h0000_007f);
    apb(1'b1, REG_PEND_BASE, 32'h8000_0003);
    rd_chk("pend on enabled only", REG_PEND_BASE, 32'h8000_0000);
    apb(1'b1, REG_PEND_BASE, 32'h0000_0000);
    apb(1'b1, REG_PEND_BASE, 32'h8000_0000);
    rd_chk("pend view keeps pending", REG_PEND_BASE, 32'h8000_0000);
    rd_chk("pending-clear view", REG_PEND_CLR_BASE, 32'h8000_0000);
    u_irqep_core_model.mark_active(31, 1'b1);
    apb(1'b1, REG_PEND_CLR_BASE, 32'h8000_0000);
    rd_chk("clear blocked when active", REG_PEND_BASE, 32'h8000_0000);
    u_irqep_core_model.mark_active(31, 1'b0);
    apb(1'b1, REG_PEND_CLR_BASE, 32'h8000_0000);
    rd_chk("clear when idle", REG_PEND_BASE, 32'h0000_0000);
    u_irqep_core_model.pulse(96, 3);
    u_irqep_core_model.pulse(33, 1);
    rd_chk("source on enabled line", REG_PEND_BASE + 12'h00c, 32'h0000_0001);
    rd_chk("source on disabled line", REG_PEND_BASE + 12'h004, 32'h0000_0000);
    apb(1'b1, REG_PEND_BASE + 12'h00c, 32'hffff_ffff);
    rd_chk("pend word 3 packing", REG_PEND_BASE + 12'h00c, 32'h0000_007f);
    @(negedge sys_clk);
    check("pending lines 102..96", {25'h0, pend[102:96]}, 32'h0000_007f);
    apb(1'b1, 12'h040, 32'h0000_0000);
    check("unmapped write error", {31'h0, err}, 32'h0000_0001);
    rd_chk("unmapped read data", 12'h040, 32'h0000_0000);
    check("unmapped read error", {31'h0, err}, 32'h0000_0001);
    rd_chk("state after unmapped", REG_DISABLE_BASE + 12'h00c, 32'h0000_007f);
    summarize();
  end
endmodule // irqep_regs_test
